//--- shared/ttfm_pkg.sv
// constants shared by the two-trip fault memory
package ttfm_pkg;

    // default sizes
    localparam int NUM_FAULTS_DEF  = 8;
    localparam int NUM_MON_DEF     = 4;

    // drive-count field
    localparam int COUNT_W           = 8;
    localparam logic [7:0] COUNT_ZERO       = 8'h00;
    localparam logic [7:0] COUNT_MAX        = 8'hfe;
    localparam logic [7:0] COUNT_FIRST_TRIP = 8'hff;

    // snapshot priority, a lower number wins; zero means the slot is empty
    localparam int PRIO_W                   = 2;
    localparam logic [1:0] PRIO_NONE        = 2'h0;
    localparam logic [1:0] PRIO_HIGH        = 2'h1;
    localparam logic [1:0] PRIO_NORMAL      = 2'h2;
    localparam logic [1:0] PRIO_PENDING     = 2'h3;

    // snapshot field widths
    localparam int RPM_W      = 16;
    localparam int SPEED_W    = 8;
    localparam int COOLANT_W  = 8;
    localparam int LOAD_W     = 8;
    localparam int TRIM_W     = 8;
    localparam int THROTTLE_W = 8;
    localparam int IAT_W      = 8;

endpackage

//--- logic/ttfm_core.sv
// two-trip fault memory: pending and confirmed codes, lamp, snapshot slot, readiness
`timescale 1ns/1ns
`default_nettype none
// How it works
// - first detection stores pending code, lamp off
// - clean diagnosed next trip clears pending code
// - repeat next trip confirms code, lamp on
// - non-diagnosed trip keeps pending code unchanged
// - lamp-first classes confirm at first detection
// - pending and confirmed share index, latest result
// - after erase no pending until redetected
// - drives since detection counted, zero while detected
// - pending-only code reports first-trip marker
// - snapshot captures operating conditions at detection
// - single snapshot slot, pending or confirmed
// - pending snapshot replaced by different pending code
// - confirmed snapshot blocks further pending snapshots
// - priorities: misfire/fuel 1, others 2, pending 3
// - higher priority replaces, equal confirmed priority keeps original
// - erase clears codes and snapshot
// - readiness completes on run, sticky until erase
// - erase or power loss resets all readiness
// - fail-safe lights lamp at once
module ttfm_core #(
    parameter int NUM_FAULTS = ttfm_pkg::NUM_FAULTS_DEF,
    parameter int NUM_MON    = ttfm_pkg::NUM_MON_DEF
) (
    input  wire logic                                     clk_in,
    input  wire logic                                     sys_rst_in,
    input  wire logic                                     clk_en_in,
    input  wire logic                                     trip_end_in,
    input  wire logic                                     trip_pattern_ok_in,
    input  wire logic                                     detect_in,
    input  wire logic [((NUM_FAULTS > 1) ? $clog2(NUM_FAULTS) : 1)-1:0] detect_idx_in,
    input  wire logic                                     detect_high_prio_in,
    input  wire logic                                     detect_lamp_first_in,
    input  wire logic [NUM_MON-1:0]                       readiness_run_in,
    input  wire logic                                     erase_in,
    input  wire logic                                     power_loss_in,
    input  wire logic                                     failsafe_in,
    input  wire logic [ttfm_pkg::RPM_W-1:0]               engine_speed_in,
    input  wire logic [ttfm_pkg::SPEED_W-1:0]             vehicle_speed_in,
    input  wire logic [ttfm_pkg::COOLANT_W-1:0]           coolant_temp_in,
    input  wire logic [ttfm_pkg::LOAD_W-1:0]              load_in,
    input  wire logic [ttfm_pkg::TRIM_W-1:0]              short_trim_in,
    input  wire logic [ttfm_pkg::TRIM_W-1:0]              long_trim_in,
    input  wire logic [ttfm_pkg::THROTTLE_W-1:0]          throttle_in,
    input  wire logic [ttfm_pkg::IAT_W-1:0]               intake_temp_in,
    output wire logic                                     fault_lamp_out,
    output wire logic [NUM_FAULTS-1:0]                    pending_fault_code_out,
    output wire logic [NUM_FAULTS-1:0]                    confirmed_fault_code_out,
    output wire logic [NUM_FAULTS-1:0]                    detected_this_trip_out,
    output wire logic [NUM_FAULTS*ttfm_pkg::COUNT_W-1:0]  drive_count_out,
    output wire logic [NUM_MON-1:0]                       readiness_complete_out,
    output wire logic [ttfm_pkg::PRIO_W-1:0]              snap_priority_out,
    output wire logic [((NUM_FAULTS > 1) ? $clog2(NUM_FAULTS) : 1)-1:0] snap_idx_out,
    output wire logic [ttfm_pkg::RPM_W-1:0]               snap_engine_speed_out,
    output wire logic [ttfm_pkg::SPEED_W-1:0]             snap_vehicle_speed_out,
    output wire logic [ttfm_pkg::COOLANT_W-1:0]           snap_coolant_temp_out,
    output wire logic [ttfm_pkg::LOAD_W-1:0]              snap_load_out,
    output wire logic [ttfm_pkg::TRIM_W-1:0]              snap_short_trim_out,
    output wire logic [ttfm_pkg::TRIM_W-1:0]              snap_long_trim_out,
    output wire logic [ttfm_pkg::THROTTLE_W-1:0]          snap_throttle_out,
    output wire logic [ttfm_pkg::IAT_W-1:0]               snap_intake_temp_out
);

    localparam int IW = (NUM_FAULTS > 1) ? $clog2(NUM_FAULTS) : 1;
    localparam int CW = ttfm_pkg::COUNT_W;

    typedef struct packed {
        logic [NUM_FAULTS-1:0]                     pending;
        logic [NUM_FAULTS-1:0]                     confirmed;
        logic [NUM_FAULTS-1:0]                     seen;
        logic [NUM_FAULTS-1:0][CW-1:0]             count;
        logic [NUM_FAULTS-1:0][CW-1:0]             report;
        logic [NUM_MON-1:0]                        ready;
        logic                                      lamp;
        logic [ttfm_pkg::PRIO_W-1:0]               snap_prio;
        logic [IW-1:0]                             snap_idx;
        logic [ttfm_pkg::RPM_W-1:0]                snap_rpm;
        logic [ttfm_pkg::SPEED_W-1:0]              snap_speed;
        logic [ttfm_pkg::COOLANT_W-1:0]            snap_coolant;
        logic [ttfm_pkg::LOAD_W-1:0]               snap_load;
        logic [ttfm_pkg::TRIM_W-1:0]               snap_strim;
        logic [ttfm_pkg::TRIM_W-1:0]               snap_ltrim;
        logic [ttfm_pkg::THROTTLE_W-1:0]           snap_throttle;
        logic [ttfm_pkg::IAT_W-1:0]                snap_iat;
    } ttfm_state_s;

    ttfm_state_s st;
    ttfm_state_s next_st;

    // priority of a confirmed code from its class
    function automatic logic [ttfm_pkg::PRIO_W-1:0] confirmed_prio(input logic high);
        confirmed_prio = high ? ttfm_pkg::PRIO_HIGH : ttfm_pkg::PRIO_NORMAL;
    endfunction

    always_comb begin
        logic                         promote;
        logic                         new_conf;
        logic                         take_snap;
        logic [ttfm_pkg::PRIO_W-1:0]  new_prio;
        int unsigned                  di;
        promote   = 1'b0;
        new_conf  = 1'b0;
        take_snap = 1'b0;
        new_prio  = ttfm_pkg::PRIO_NONE;
        di        = 0;
        next_st   = st;

        // erase or lost retained memory wipes everything first, so a detection or readiness run
        // of the same cycle is applied on top and is not lost; a trip end of that cycle is dropped
        if (erase_in || power_loss_in) begin
            next_st.pending   = '0;
            next_st.confirmed = '0;
            next_st.seen      = '0;
            next_st.count     = '0;
            next_st.ready     = '0;
            next_st.snap_prio = ttfm_pkg::PRIO_NONE;
        end else if (trip_end_in) begin
            for (int i = 0; i < NUM_FAULTS; i++) begin
                // a trip without the driving pattern ran no diagnosis: keep the code
                if (trip_pattern_ok_in && !st.seen[i]) begin
                    next_st.pending[i] = 1'b0;
                end
                if (st.confirmed[i] && !st.seen[i] && st.count[i] < ttfm_pkg::COUNT_MAX) begin
                    next_st.count[i] = CW'(st.count[i] + 1'b1);
                end
            end
            next_st.seen = '0;
        end

        // readiness is sticky; only the wipe above clears it
        next_st.ready = next_st.ready | readiness_run_in;

        // indices beyond the table are ignored
        if (detect_in && (int'(detect_idx_in) < NUM_FAULTS)) begin
            di = int'(detect_idx_in);
            // a pending code left by an earlier trip and not seen this trip means
            // this is the consecutive trip
            promote  = next_st.confirmed[di] || detect_lamp_first_in
                       || (next_st.pending[di] && !next_st.seen[di]);
            new_conf = promote && !next_st.confirmed[di];
            next_st.pending[di] = 1'b1;
            next_st.seen[di]    = 1'b1;
            next_st.count[di]   = ttfm_pkg::COUNT_ZERO;
            if (promote) begin
                next_st.confirmed[di] = 1'b1;
            end
            if (new_conf) begin
                new_prio  = confirmed_prio(detect_high_prio_in);
                take_snap = (next_st.snap_prio == ttfm_pkg::PRIO_NONE)
                            || (new_prio < next_st.snap_prio);
            end else if (!promote) begin
                new_prio  = ttfm_pkg::PRIO_PENDING;
                take_snap = (next_st.snap_prio == ttfm_pkg::PRIO_NONE)
                            || ((next_st.snap_prio == ttfm_pkg::PRIO_PENDING)
                                && (next_st.snap_idx != detect_idx_in));
            end
        end

        // one slot only: a capture overwrites whatever was there
        if (take_snap) begin
            next_st.snap_prio     = new_prio;
            next_st.snap_idx      = detect_idx_in;
            next_st.snap_rpm      = engine_speed_in;
            next_st.snap_speed    = vehicle_speed_in;
            next_st.snap_coolant  = coolant_temp_in;
            next_st.snap_load     = load_in;
            next_st.snap_strim    = short_trim_in;
            next_st.snap_ltrim    = long_trim_in;
            next_st.snap_throttle = throttle_in;
            next_st.snap_iat      = intake_temp_in;
        end

        for (int i = 0; i < NUM_FAULTS; i++) begin
            if (next_st.confirmed[i]) begin
                next_st.report[i] = next_st.count[i];
            end else if (next_st.pending[i]) begin
                next_st.report[i] = ttfm_pkg::COUNT_FIRST_TRIP;
            end else begin
                next_st.report[i] = ttfm_pkg::COUNT_ZERO;
            end
        end

        // pending-only codes never light the lamp
        next_st.lamp = (|next_st.confirmed) || failsafe_in;
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st <= '0;
        end else if (clk_en_in) begin
            st <= next_st;
        end
    end

    assign fault_lamp_out           = st.lamp;
    assign pending_fault_code_out   = st.pending;
    assign confirmed_fault_code_out = st.confirmed;
    assign detected_this_trip_out   = st.seen;
    assign drive_count_out          = st.report;
    assign readiness_complete_out   = st.ready;
    assign snap_priority_out        = st.snap_prio;
    assign snap_idx_out             = st.snap_idx;
    assign snap_engine_speed_out    = st.snap_rpm;
    assign snap_vehicle_speed_out   = st.snap_speed;
    assign snap_coolant_temp_out    = st.snap_coolant;
    assign snap_load_out            = st.snap_load;
    assign snap_short_trim_out      = st.snap_strim;
    assign snap_long_trim_out       = st.snap_ltrim;
    assign snap_throttle_out        = st.snap_throttle;
    assign snap_intake_temp_out     = st.snap_iat;

endmodule
`default_nettype wire

//--- verif/ttfm_checker.sv
// concurrent checks on the fault memory ports
`timescale 1ns/1ns
`default_nettype none
module ttfm_checker #(
    parameter int NUM_FAULTS = 8,
    parameter int NUM_MON    = 4
) (
    input wire logic                          clk_in,
    input wire logic                          sys_rst_in,
    input wire logic                          clk_en_in,
    input wire logic                          detect_in,
    input wire logic [$clog2(NUM_FAULTS)-1:0] detect_idx_in,
    input wire logic                          detect_lamp_first_in,
    input wire logic                          erase_in,
    input wire logic                          power_loss_in,
    input wire logic                          failsafe_in,
    input wire logic [NUM_MON-1:0]            readiness_run_in,
    input wire logic                          fault_lamp_out,
    input wire logic [NUM_FAULTS-1:0]         pending_fault_code_out,
    input wire logic [NUM_FAULTS-1:0]         confirmed_fault_code_out,
    input wire logic [NUM_FAULTS-1:0]         detected_this_trip_out,
    input wire logic [NUM_FAULTS*8-1:0]       drive_count_out,
    input wire logic [NUM_MON-1:0]            readiness_complete_out,
    input wire logic [1:0]                    snap_priority_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    wire logic wipe = erase_in | power_loss_in;
    lamp_on_confirmed_a: assert property (|confirmed_fault_code_out |-> fault_lamp_out)
        else $error("lamp off while a confirmed code is stored");
    pending_store_a: assert property (clk_en_in && detect_in |=> pending_fault_code_out[$past(detect_idx_in)])
        else $error("detection left no pending code");
    lamp_first_a: assert property (clk_en_in && detect_in && detect_lamp_first_in |=>
        confirmed_fault_code_out[$past(detect_idx_in)] && fault_lamp_out) else $error("lamp-first class not confirmed");
    count_marker_a: assert property (pending_fault_code_out[2] && !confirmed_fault_code_out[2] |->
        drive_count_out[23:16] == 8'hff) else $error("pending-only code without first-trip marker");
    count_zero_a: assert property (confirmed_fault_code_out[2] && detected_this_trip_out[2] |->
        drive_count_out[23:16] == 8'h00) else $error("drive count not zero while detected");
    erase_all_a: assert property (clk_en_in && wipe && !detect_in && readiness_run_in == '0 |=>
        confirmed_fault_code_out == '0 && pending_fault_code_out == '0 && readiness_complete_out == '0
        && snap_priority_out == 2'h0) else $error("erase left state behind");
    ready_sticky_a: assert property (|(~readiness_complete_out & $past(readiness_complete_out)) |->
        $past(wipe)) else $error("readiness dropped without erase");
    confirm_sticky_a: assert property (|(~confirmed_fault_code_out & $past(confirmed_fault_code_out)) |->
        $past(wipe)) else $error("confirmed code dropped without erase");
    no_pending_snap_a: assert property ($past(snap_priority_out) inside {2'h1, 2'h2} && !$past(wipe) |->
        snap_priority_out inside {2'h1, 2'h2}) else $error("pending snapshot over confirmed one");
    top_prio_keep_a: assert property ($past(snap_priority_out) == 2'h1 && !$past(wipe) |->
        snap_priority_out == 2'h1) else $error("priority one snapshot replaced");
    failsafe_lamp_a: assert property (failsafe_in && $past(failsafe_in) && $past(clk_en_in) |-> fault_lamp_out)
        else $error("lamp off in fail-safe");
    cover property (detect_in && detect_lamp_first_in);
    cover property (snap_priority_out == 2'h1);
    cover property (wipe && |confirmed_fault_code_out);
endmodule
bind ttfm_core ttfm_checker #(.NUM_FAULTS(NUM_FAULTS), .NUM_MON(NUM_MON)) i_ttfm_checker (.*);
`default_nettype wire

//--- verif/ttfm_scan_tool.sv
// scan tool model: reads the confirmed codes and issues erase pulses
`timescale 1ns/1ns
`default_nettype none
module ttfm_scan_tool (
    input  wire logic       clk_in,
    input  wire logic       erase_req_in,
    input  wire logic [7:0] confirmed_in,
    output var  logic       erase_out,
    output var  logic [7:0] read_codes_out
);
    logic req_d = 1'b0;
    initial erase_out = 1'b0;
    initial read_codes_out = 8'h00;
    // codes are read before the wipe, one erase pulse per request edge
    always @(negedge clk_in) begin
        req_d <= erase_req_in;
        erase_out <= erase_req_in & ~req_d;
        if (erase_req_in & ~req_d) begin
            read_codes_out <= confirmed_in;
        end
    end
endmodule
`default_nettype wire

//--- verif/tb.sv
// self-checking bench for the two-trip fault memory
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk_in = 0, sys_rst_in = 1, clk_en_in = 1, trip_end_in = 0, trip_pattern_ok_in = 0, detect_in = 0;
    logic detect_high_prio_in = 0, detect_lamp_first_in = 0, power_loss_in = 0, failsafe_in = 0, scan_req = 0;
    logic [2:0] detect_idx_in = 0, snap_idx_out;
    logic [3:0] readiness_run_in = 0, readiness_complete_out;
    logic [15:0] engine_speed_in = 0, snap_engine_speed_out;
    logic [7:0] vehicle_speed_in = 0, coolant_temp_in = 0, load_in = 0, short_trim_in = 0, long_trim_in = 0;
    logic [7:0] throttle_in = 0, intake_temp_in = 0, snap_vehicle_speed_out, snap_coolant_temp_out, snap_load_out;
    logic [7:0] snap_short_trim_out, snap_long_trim_out, snap_throttle_out, snap_intake_temp_out, read_codes;
    logic [7:0] pending_fault_code_out, confirmed_fault_code_out, detected_this_trip_out;
    logic [63:0] drive_count_out;
    logic [1:0] snap_priority_out;
    logic fault_lamp_out;
    wire logic erase_in;
    int n_errors = 0;
    int comparisons = 0;
    ttfm_core i_ttfm_core (.*);
    ttfm_scan_tool i_ttfm_scan_tool (.clk_in(clk_in), .erase_req_in(scan_req), .confirmed_in(confirmed_fault_code_out),
        .erase_out(erase_in), .read_codes_out(read_codes));
    always #5 clk_in = ~clk_in;
    task automatic summarize();
        if (n_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic tick();
        @(negedge clk_in);
    endtask
    task automatic det(input logic [2:0] i, input logic hp, input logic lf);
        {detect_in, detect_idx_in, detect_high_prio_in, detect_lamp_first_in} = {1'b1, i, hp, lf};
        engine_speed_in = 16'h1000 + {13'h0000, i};
        {vehicle_speed_in, coolant_temp_in, load_in, short_trim_in, long_trim_in, throttle_in, intake_temp_in}
            = {7{8'h40 + {5'h00, i}}};
        tick();
        detect_in = 0;
    endtask
    task automatic trip(input logic ok);
        {trip_end_in, trip_pattern_ok_in} = {1'b1, ok};
        tick();
        {trip_end_in, trip_pattern_ok_in} = 2'b00;
    endtask
    task automatic s_two_trip();
        det(3'h4, 0, 0);
        chk(pending_fault_code_out[4] === 1'b1 && fault_lamp_out === 1'b0 && snap_priority_out === 2'h3, "first");
        det(3'h2, 0, 0);
        chk(pending_fault_code_out === 8'h14 && snap_idx_out === 3'h2 && drive_count_out[23:16] === 8'hff, "pend");
        chk(snap_engine_speed_out === 16'h1002 && snap_intake_temp_out === 8'h42 && snap_load_out === 8'h42, "snap");
        trip(0);
        chk(pending_fault_code_out === 8'h14 && confirmed_fault_code_out === 8'h00, "kept");
        det(3'h2, 0, 0);
        chk(confirmed_fault_code_out === 8'h04 && pending_fault_code_out[2] === 1'b1 && fault_lamp_out === 1'b1, "conf");
        chk(drive_count_out[23:16] === 8'h00 && snap_priority_out === 2'h2 && snap_idx_out === 3'h2, "count0");
        trip(1);
        chk(pending_fault_code_out === 8'h04 && drive_count_out[23:16] === 8'h00, "detected trip ends");
        trip(1);
        chk(pending_fault_code_out === 8'h00 && confirmed_fault_code_out === 8'h04, "clean trip");
        chk(drive_count_out[23:16] === 8'h01 && fault_lamp_out === 1'b1, "drives");
    endtask
    task automatic s_snapshot();
        det(3'h5, 0, 0);
        chk(pending_fault_code_out[5] === 1'b1 && snap_priority_out === 2'h2 && snap_idx_out === 3'h2, "blocked");
        det(3'h1, 1, 1);
        chk(confirmed_fault_code_out === 8'h06 && snap_priority_out === 2'h1 && snap_idx_out === 3'h1, "prio1");
        det(3'h3, 1, 1);
        chk(confirmed_fault_code_out === 8'h0e && snap_priority_out === 2'h1 && snap_idx_out === 3'h1, "equal");
    endtask
    task automatic s_erase();
        readiness_run_in = 4'h5;
        tick();
        readiness_run_in = 4'h0;
        trip(1);
        chk(readiness_complete_out === 4'h5, "ready");
        scan_req <= 1'b1;
        tick();
        tick();
        scan_req <= 1'b0;
        chk(read_codes === 8'h0e && confirmed_fault_code_out === 8'h00 && pending_fault_code_out === 8'h00, "erase");
        chk(readiness_complete_out === 4'h0 && snap_priority_out === 2'h0 && fault_lamp_out === 1'b0, "wiped");
        readiness_run_in = 4'h2;
        tick();
        readiness_run_in = 4'h0;
        power_loss_in = 1;
        tick();
        power_loss_in = 0;
        chk(readiness_complete_out === 4'h0, "power loss");
        det(3'h6, 0, 0);
        chk(pending_fault_code_out === 8'h40 && confirmed_fault_code_out === 8'h00, "after erase");
    endtask
    task automatic s_failsafe();
        failsafe_in = 1;
        tick();
        tick();
        chk(fault_lamp_out === 1'b1, "failsafe on");
        failsafe_in = 0;
        tick();
        tick();
        chk(fault_lamp_out === 1'b0, "failsafe off");
        clk_en_in = 0;
        det(3'h7, 0, 0);
        clk_en_in = 1;
        chk(pending_fault_code_out === 8'h40 && snap_idx_out === 3'h6, "frozen");
    endtask
    initial begin
        #100000;
        n_errors++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge clk_in);
        tick();
        sys_rst_in = 0;
        chk(fault_lamp_out === 1'b0 && snap_priority_out === 2'h0 && confirmed_fault_code_out === 8'h00, "reset");
        s_two_trip();
        s_snapshot();
        s_erase();
        s_failsafe();
        summarize();
    end
endmodule
`default_nettype wire
